// ==== src/dpm_monitor.sv ====
// ds1 line/path performance monitor with pointer justification counters, apb slave
module dpm_monitor
  import dpm_pkg::*;
#(
  parameter int TICK_CYCLES = DPM_TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [DPM_ADDR_W-1:0] apb_paddr_in,
  input wire logic [DPM_DATA_W-1:0] apb_pwdata_in,
  input wire logic [3:0] apb_pstrb_in,
  input wire dpm_line_ev_t line_ev_in,
  input wire dpm_path_ev_t path_ev_in,
  input wire dpm_pj_ev_t pj_ev_in,
  output logic [DPM_DATA_W-1:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  output logic path_unavailable_out,
  output logic [DPM_NUM_PM-1:0] threshold_flags_out
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > (2 ** DPM_TICK_W)) begin : g_tick_check
    $error("TICK_CYCLES out of range for the second counter");
  end

  dpm_state_t state;
  dpm_state_t next_state;

  function automatic logic [DPM_CNT_W-1:0] sat_add(input logic [DPM_CNT_W-1:0] a,
                                                   input logic [3:0] b);
    logic [DPM_CNT_W:0] s;
    s = {1'b0, a} + {{(DPM_CNT_W - 3){1'b0}}, b};
    return s[DPM_CNT_W] ? {DPM_CNT_W{1'b1}} : s[DPM_CNT_W-1:0];
  endfunction

  function automatic logic [DPM_TALLY_W-1:0] tally_add(input logic [DPM_TALLY_W-1:0] a,
                                                       input logic [1:0] b);
    logic [DPM_TALLY_W:0] s;
    s = {1'b0, a} + {{(DPM_TALLY_W - 1){1'b0}}, b};
    return s[DPM_TALLY_W] ? {DPM_TALLY_W{1'b1}} : s[DPM_TALLY_W-1:0];
  endfunction

  function automatic logic [DPM_DATA_W-1:0] merge(input logic [DPM_DATA_W-1:0] old,
                                                  input logic [DPM_DATA_W-1:0] wd,
                                                  input logic [3:0] strb);
    logic [DPM_DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // combinational views of this cycle
  logic tick;
  logic [1:0] line_inc;
  logic path_err_ev;
  logic [DPM_TALLY_W-1:0] line_anom_sec;
  logic [DPM_TALLY_W-1:0] path_err_sec;
  logic los_sec;
  logic align_sec;
  logic sevf_sec;
  logic ais_sec;
  logic path_ses;
  logic line_ses;
  logic [3:0] unavail_add;
  logic [DPM_NUM_PM-1:0][3:0] pm_inc;
  logic [DPM_NUM_PJ-1:0] pj_hit;
  logic [DPM_NUM_PM-1:0][DPM_CNT_W-1:0] pm_before;
  logic apb_access;
  logic apb_done;
  logic [DPM_ADDR_W-1:0] ofs;
  logic [DPM_DATA_W-1:0] rdata;
  logic rerr;
  logic [DPM_DATA_W-1:0] ctrl_word;
  logic [DPM_DATA_W-1:0] ctrl_new;

  always_comb begin
    next_state = state;
    tick = (state.tick_cnt == DPM_TICK_W'(TICK_CYCLES - 1));
    next_state.tick_cnt = tick ? '0 : state.tick_cnt + 1'b1;

    line_inc = {1'b0, line_ev_in.bipolar_violation} + {1'b0, line_ev_in.excess_zeros_event};
    path_err_ev = state.esf_mode ? path_ev_in.crc6_error : path_ev_in.frame_bit_error;

    // this second's totals, including events arriving with the tick
    line_anom_sec = tally_add(state.line_anomalies, line_inc);
    path_err_sec = tally_add(state.path_errors, {1'b0, path_err_ev});
    los_sec = state.los_seen | line_ev_in.los_defect;
    align_sec = state.align_change_seen | path_ev_in.frame_align_change;
    sevf_sec = state.severe_frame_seen | path_ev_in.severe_frame_error_defect;
    ais_sec = state.ais_seen | path_ev_in.ais_defect;

    line_ses = (line_anom_sec >= DPM_LINE_SES_LIMIT) | los_sec;
    path_ses = (state.esf_mode ? (path_err_sec >= DPM_ESF_SES_LIMIT)
                               : (path_err_sec >= DPM_SF_SES_LIMIT)) | sevf_sec | ais_sec;

    pm_inc = '0;
    pm_inc[DPM_LINE_CODE_VIOL] = {2'b00, line_inc};
    pm_inc[DPM_PATH_CODE_VIOL] = {3'b000, path_err_ev};
    unavail_add = 4'h0;
    if (tick) begin
      pm_inc[DPM_LINE_ERR_SEC] = {3'b000, (line_anom_sec != '0) | los_sec};
      pm_inc[DPM_LINE_SEV_SEC] = {3'b000, line_ses};
      pm_inc[DPM_LINE_LOS_SEC] = {3'b000, los_sec};
      pm_inc[DPM_PATH_ERR_SEC] = {3'b000,
                                  (path_err_sec != '0) | align_sec | sevf_sec | ais_sec};
      pm_inc[DPM_PATH_SEV_SEC] = {3'b000, path_ses};
      pm_inc[DPM_PATH_FRAME_AIS_SEC] = {3'b000, sevf_sec | ais_sec};
      pm_inc[DPM_PATH_AIS_SEC] = {3'b000, ais_sec};

      case (state.avail)
        DPM_AVAIL: begin
          if (path_ses) begin
            next_state.run = state.run + 4'h1;
            if (state.run + 4'h1 == DPM_UNAVAIL_RUN) begin
              // onset of the run is unavailable, so the whole run is added at once
              next_state.avail = DPM_UNAVAIL;
              next_state.run = 4'h0;
              unavail_add = DPM_UNAVAIL_RUN;
            end
          end else begin
            next_state.run = 4'h0;
          end
        end
        DPM_UNAVAIL: begin
          if (path_ses) begin
            // clean seconds held back turn out to be unavailable after all
            unavail_add = state.run + 4'h1;
            next_state.run = 4'h0;
          end else begin
            next_state.run = state.run + 4'h1;
            if (state.run + 4'h1 == DPM_UNAVAIL_RUN) begin
              next_state.avail = DPM_AVAIL;
              next_state.run = 4'h0;
            end
          end
        end
        default: begin
          next_state.avail = DPM_AVAIL;
          next_state.run = 4'h0;
        end
      endcase
      pm_inc[DPM_PATH_UNAVAIL_SEC] = unavail_add;

      // tallies restart with the new second
      next_state.line_anomalies = '0;
      next_state.path_errors = '0;
      next_state.los_seen = 1'b0;
      next_state.align_change_seen = 1'b0;
      next_state.severe_frame_seen = 1'b0;
      next_state.ais_seen = 1'b0;
    end else begin
      next_state.line_anomalies = line_anom_sec;
      next_state.path_errors = path_err_sec;
      next_state.los_seen = los_sec;
      next_state.align_change_seen = align_sec;
      next_state.severe_frame_seen = sevf_sec;
      next_state.ais_seen = ais_sec;
    end

    pj_hit = '0;
    if (state.pj_enable && pj_ev_in.sts == state.justification_monitor_sts_select) begin
      pj_hit[DPM_PJ_POS_DET] = pj_ev_in.positive_just_detected;
      pj_hit[DPM_PJ_POS_GEN] = pj_ev_in.positive_just_generated;
      pj_hit[DPM_PJ_NEG_DET] = pj_ev_in.negative_just_detected;
      pj_hit[DPM_PJ_NEG_GEN] = pj_ev_in.negative_just_generated;
    end

    // apb decode and read data
    apb_access = apb_psel_in & apb_penable_in;
    apb_done = apb_access & state.pready;
    ofs = apb_paddr_in;
    ctrl_word = '0;
    ctrl_word[DPM_CTRL_ESF_BIT] = state.esf_mode;
    ctrl_word[DPM_CTRL_PJ_EN_BIT] = state.pj_enable;
    ctrl_word[DPM_CTRL_STS_LSB +: DPM_STS_W] = state.justification_monitor_sts_select;
    ctrl_new = merge(ctrl_word, apb_pwdata_in, apb_pstrb_in);
    rdata = '0;
    rerr = 1'b0;
    if (ofs == DPM_CTRL_OFS) begin
      rdata = ctrl_word;
    end else if (ofs == DPM_STATUS_OFS) begin
      rdata[DPM_STATUS_UNAVAIL_BIT] = (state.avail == DPM_UNAVAIL);
      rdata[DPM_STATUS_RUN_LSB +: 4] = state.run;
    end else if (ofs == DPM_FLAGS_OFS) begin
      rdata[DPM_NUM_PM-1:0] = state.flags;
    end else if (ofs[1:0] == 2'b00 && ofs >= DPM_PM_BASE
                 && ofs < DPM_PM_BASE + DPM_ADDR_W'(4 * DPM_NUM_PM)) begin
      rdata = state.pm[ofs[5:2]];
    end else if (ofs[1:0] == 2'b00 && ofs >= DPM_PJ_BASE
                 && ofs < DPM_PJ_BASE + DPM_ADDR_W'(4 * DPM_NUM_PJ)) begin
      rdata = state.pj_enable ? state.pj[ofs[3:2]] : '0;
    end else if (ofs[1:0] == 2'b00 && ofs >= DPM_THR_BASE
                 && ofs < DPM_THR_BASE + DPM_ADDR_W'(4 * DPM_NUM_PM)) begin
      rdata = state.thr[ofs[5:2] - 4'h0];
    end else begin
      rerr = 1'b1;
    end

    // answer one cycle into the access phase; registered so outputs stay glitch free
    next_state.pready = apb_access & ~state.pready;
    next_state.pslverr = apb_access & ~state.pready & rerr;
    if (apb_access & ~state.pready) begin
      next_state.prdata = apb_pwrite_in ? '0 : rdata;
    end

    // software writes first, so hardware events in the same cycle win
    if (apb_done && apb_pwrite_in && !rerr) begin
      if (ofs == DPM_CTRL_OFS) begin
        next_state.esf_mode = ctrl_new[DPM_CTRL_ESF_BIT];
        next_state.pj_enable = ctrl_new[DPM_CTRL_PJ_EN_BIT];
        next_state.justification_monitor_sts_select = ctrl_new[DPM_CTRL_STS_LSB +: DPM_STS_W];
      end else if (ofs == DPM_FLAGS_OFS) begin
        next_state.flags = state.flags & ~apb_pwdata_in[DPM_NUM_PM-1:0];
      end else if (ofs >= DPM_THR_BASE) begin
        next_state.thr[ofs[5:2]] = merge(state.thr[ofs[5:2]], apb_pwdata_in, apb_pstrb_in);
      end else if (ofs >= DPM_PJ_BASE) begin
        next_state.pj[ofs[3:2]] = '0;
      end else if (ofs >= DPM_PM_BASE) begin
        next_state.pm[ofs[5:2]] = '0;
      end
    end

    pm_before = next_state.pm;
    for (int i = 0; i < DPM_NUM_PM; i++) begin
      next_state.pm[i] = sat_add(pm_before[i], pm_inc[i]);
      if (pm_inc[i] != 4'h0 && next_state.pm[i] >= state.thr[i]
          && pm_before[i] < state.thr[i]) begin
        next_state.flags[i] = 1'b1;
      end
    end
    for (int j = 0; j < DPM_NUM_PJ; j++) begin
      next_state.pj[j] = sat_add(next_state.pj[j], {3'b000, pj_hit[j]});
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.avail <= DPM_AVAIL;
      state.justification_monitor_sts_select <= DPM_STS_RESET;
      state.thr <= {DPM_NUM_PM{DPM_THR_RESET}};
    end else begin
      state <= next_state;
    end
  end

  assign apb_prdata_out = state.prdata;
  assign apb_pready_out = state.pready;
  assign apb_pslverr_out = state.pslverr;
  assign path_unavailable_out = (state.avail == DPM_UNAVAIL);
  assign threshold_flags_out = state.flags;

endmodule // dpm_monitor

// ==== src/dpm_pkg.sv ====
// package: constants, carriers and state type of the ds1 performance monitor
package dpm_pkg;
  // bus and counter geometry
  localparam int DPM_ADDR_W = 12;
  localparam int DPM_DATA_W = 32;
  localparam int DPM_CNT_W = 32;
  localparam int DPM_TALLY_W = 16;
  localparam int DPM_STS_W = 6;
  localparam int DPM_TICK_W = 26;
  localparam int DPM_NUM_PM = 10;
  localparam int DPM_NUM_PJ = 4;
  // second tick timing
  localparam longint DPM_SECOND_NS = 1000000000;
  localparam longint DPM_CLK_NS = 20;
  localparam int DPM_TICK_CYCLES = int'(DPM_SECOND_NS / DPM_CLK_NS);
  // per-second thresholds and unavailability run length
  localparam logic [DPM_TALLY_W-1:0] DPM_LINE_SES_LIMIT = 16'h0608;
  localparam logic [DPM_TALLY_W-1:0] DPM_ESF_SES_LIMIT = 16'h0140;
  localparam logic [DPM_TALLY_W-1:0] DPM_SF_SES_LIMIT = 16'h0004;
  localparam logic [3:0] DPM_UNAVAIL_RUN = 4'ha;
  // register offsets
  localparam logic [DPM_ADDR_W-1:0] DPM_CTRL_OFS = 12'h000;
  localparam logic [DPM_ADDR_W-1:0] DPM_STATUS_OFS = 12'h004;
  localparam logic [DPM_ADDR_W-1:0] DPM_FLAGS_OFS = 12'h008;
  localparam logic [DPM_ADDR_W-1:0] DPM_PM_BASE = 12'h040;
  localparam logic [DPM_ADDR_W-1:0] DPM_PJ_BASE = 12'h080;
  localparam logic [DPM_ADDR_W-1:0] DPM_THR_BASE = 12'h0c0;
  // control and status fields
  localparam int DPM_CTRL_ESF_BIT = 0;
  localparam int DPM_CTRL_PJ_EN_BIT = 1;
  localparam int DPM_CTRL_STS_LSB = 8;
  localparam int DPM_STATUS_UNAVAIL_BIT = 0;
  localparam int DPM_STATUS_RUN_LSB = 4;
  // performance counter indices
  localparam int DPM_LINE_CODE_VIOL = 0;
  localparam int DPM_LINE_ERR_SEC = 1;
  localparam int DPM_LINE_SEV_SEC = 2;
  localparam int DPM_LINE_LOS_SEC = 3;
  localparam int DPM_PATH_CODE_VIOL = 4;
  localparam int DPM_PATH_ERR_SEC = 5;
  localparam int DPM_PATH_SEV_SEC = 6;
  localparam int DPM_PATH_FRAME_AIS_SEC = 7;
  localparam int DPM_PATH_AIS_SEC = 8;
  localparam int DPM_PATH_UNAVAIL_SEC = 9;
  // justification counter indices
  localparam int DPM_PJ_POS_DET = 0;
  localparam int DPM_PJ_POS_GEN = 1;
  localparam int DPM_PJ_NEG_DET = 2;
  localparam int DPM_PJ_NEG_GEN = 3;
  // reset values
  localparam logic [DPM_CNT_W-1:0] DPM_THR_RESET = 32'hffffffff;
  localparam logic [DPM_STS_W-1:0] DPM_STS_RESET = 6'h00;

  typedef enum logic [0:0] {
    DPM_AVAIL = 1'b0,
    DPM_UNAVAIL = 1'b1
  } dpm_avail_t;

  typedef struct packed {
    logic bipolar_violation;
    logic excess_zeros_event;
    logic los_defect;
  } dpm_line_ev_t;

  typedef struct packed {
    logic crc6_error;
    logic frame_bit_error;
    logic frame_align_change;
    logic severe_frame_error_defect;
    logic ais_defect;
  } dpm_path_ev_t;

  typedef struct packed {
    logic [DPM_STS_W-1:0] sts;
    logic positive_just_detected;
    logic positive_just_generated;
    logic negative_just_detected;
    logic negative_just_generated;
  } dpm_pj_ev_t;

  typedef struct packed {
    logic esf_mode;
    logic pj_enable;
    logic [DPM_STS_W-1:0] justification_monitor_sts_select;
    logic [DPM_TICK_W-1:0] tick_cnt;
    logic [DPM_TALLY_W-1:0] line_anomalies;
    logic los_seen;
    logic [DPM_TALLY_W-1:0] path_errors;
    logic align_change_seen;
    logic severe_frame_seen;
    logic ais_seen;
    dpm_avail_t avail;
    logic [3:0] run;
    logic [DPM_NUM_PM-1:0][DPM_CNT_W-1:0] pm;
    logic [DPM_NUM_PJ-1:0][DPM_CNT_W-1:0] pj;
    logic [DPM_NUM_PM-1:0][DPM_CNT_W-1:0] thr;
    logic [DPM_NUM_PM-1:0] flags;
    logic pready;
    logic pslverr;
    logic [DPM_DATA_W-1:0] prdata;
  } dpm_state_t;
endpackage

// ==== verif/dpm_monitor_assertions.sv ====
// concurrent port checks for the ds1 performance monitor
module dpm_monitor_assertions
  import dpm_pkg::*;
#(
  parameter int TICK_CYCLES = DPM_TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [DPM_ADDR_W-1:0] apb_paddr_in,
  input wire logic [DPM_DATA_W-1:0] apb_prdata_out,
  input wire logic apb_pready_out,
  input wire logic apb_pslverr_out,
  input wire logic path_unavailable_out,
  input wire logic [DPM_NUM_PM-1:0] threshold_flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc;
  assign acc = apb_psel_in && apb_penable_in && !apb_pready_out;
  a_one_wait: assert property (acc |=> apb_pready_out)
    else $error("pready late after access phase");
  a_ready_pulse: assert property (apb_pready_out |=> !apb_pready_out)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (apb_pready_out |-> $past(apb_psel_in && apb_penable_in))
    else $error("pready without access phase");
  a_err_ready: assert property (apb_pslverr_out |-> apb_pready_out)
    else $error("pslverr without pready");
  a_bad_addr: assert property (
    acc && (apb_paddr_in[1:0] != 2'b00 || apb_paddr_in >= 12'h100) |=> apb_pslverr_out)
    else $error("unmapped address not refused");
  a_write_zero: assert property (acc && apb_pwrite_in |=> apb_prdata_out == '0)
    else $error("read data not zero on write");
  // a flag may only drop through a completed flags write
  a_flag_sticky: assert property (
    |($past(threshold_flags_out) & ~threshold_flags_out) |->
    $past(apb_pwrite_in && apb_pready_out && apb_paddr_in == DPM_FLAGS_OFS))
    else $error("threshold flag dropped on its own");
  a_unavail_hold: assert property (
    $rose(path_unavailable_out) |=> path_unavailable_out [*8])
    else $error("unavailable left too soon");
  a_avail_hold: assert property (
    $fell(path_unavailable_out) |=> (!path_unavailable_out) [*8])
    else $error("unavailable entered too soon");
endmodule // dpm_monitor_assertions

bind dpm_monitor dpm_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_dpm_chk (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .apb_psel_in(apb_psel_in),
  .apb_penable_in(apb_penable_in),
  .apb_pwrite_in(apb_pwrite_in),
  .apb_paddr_in(apb_paddr_in),
  .apb_prdata_out(apb_prdata_out),
  .apb_pready_out(apb_pready_out),
  .apb_pslverr_out(apb_pslverr_out),
  .path_unavailable_out(path_unavailable_out),
  .threshold_flags_out(threshold_flags_out)
);

// ==== verif/dpm_framer_model.sv ====
// behavioural ds1 framer and defect detector feeding the monitor
module dpm_framer_model
  import dpm_pkg::*;
(
  input wire logic clk_in,
  output dpm_line_ev_t line_ev_out,
  output dpm_path_ev_t path_ev_out,
  output dpm_pj_ev_t pj_ev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_ev_out = '0;
    path_ev_out = '0;
    pj_ev_out = '0;
  end
  // one idle edge first, so back-to-back calls never assign twice in one step
  task automatic send(input dpm_line_ev_t l, input dpm_path_ev_t p, input dpm_pj_ev_t j,
                      input int n);
    @(posedge clk_in);
    line_ev_out <= l;
    path_ev_out <= p;
    pj_ev_out <= j;
    repeat (n) @(posedge clk_in);
    line_ev_out <= '0;
    path_ev_out <= '0;
    pj_ev_out <= '0;
  endtask
endmodule // dpm_framer_model

// ==== verif/dpm_monitor_tb.sv ====
// self-checking bench for the ds1 performance monitor
module dpm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpm_pkg::*;
  // short second keeps the run small; 1544 anomalies still fit at two per cycle
  localparam int T = 1000;
  typedef struct {bit esf; logic [2:0] l; logic [4:0] p; int n; int e[10];} row_t;
  row_t rows [10] = '{
    '{1'b0, 3'b110, 5'h00, 772, '{1544, 1, 1, 0, 0, 0, 0, 0, 0, 0}},
    '{1'b0, 3'b100, 5'h00, 5, '{5, 1, 0, 0, 0, 0, 0, 0, 0, 0}},
    '{1'b0, 3'b001, 5'h00, 1, '{0, 1, 1, 1, 0, 0, 0, 0, 0, 0}},
    '{1'b0, 3'b000, 5'h18, 3, '{0, 0, 0, 0, 3, 1, 0, 0, 0, 0}},
    '{1'b0, 3'b000, 5'h08, 4, '{0, 0, 0, 0, 4, 1, 1, 0, 0, 0}},
    '{1'b1, 3'b000, 5'h10, 320, '{0, 0, 0, 0, 320, 1, 1, 0, 0, 0}},
    '{1'b1, 3'b000, 5'h18, 319, '{0, 0, 0, 0, 319, 1, 0, 0, 0, 0}},
    '{1'b0, 3'b000, 5'h04, 1, '{0, 0, 0, 0, 0, 1, 0, 0, 0, 0}},
    '{1'b1, 3'b000, 5'h02, 1, '{0, 0, 0, 0, 0, 1, 1, 1, 0, 0}},
    '{1'b0, 3'b000, 5'h01, 1, '{0, 0, 0, 0, 0, 1, 1, 1, 1, 0}}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic unav;
  logic [9:0] flags;
  logic [31:0] rd_v;
  logic rd_e;
  dpm_line_ev_t line_ev;
  dpm_path_ev_t path_ev;
  dpm_pj_ev_t pj_ev;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  dpm_monitor #(.TICK_CYCLES(T)) DUT (.sys_clk_in(clk), .rst_n_in(rst_n),
    .apb_psel_in(psel), .apb_penable_in(pen), .apb_pwrite_in(pwr), .apb_paddr_in(paddr),
    .apb_pwdata_in(pwdata), .apb_pstrb_in(pstrb), .line_ev_in(line_ev),
    .path_ev_in(path_ev), .pj_ev_in(pj_ev), .apb_prdata_out(prdata),
    .apb_pready_out(pready), .apb_pslverr_out(pslverr), .path_unavailable_out(unav),
    .threshold_flags_out(flags));
  dpm_framer_model fr (.clk_in(clk), .line_ev_out(line_ev), .path_ev_out(path_ev),
    .pj_ev_out(pj_ev));

  task automatic close_out();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle limit here: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_v);
  endtask
  task automatic wait_at(input int ph);
    do @(posedge clk); while (cyc % T != ph);
  endtask
  task automatic ses_second();
    wait_at(100);
    fr.send('0, 5'h02, '0, 1);
    wait_at(50);
  endtask

  initial begin
    repeat (60 * T) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd("ctrl", DPM_CTRL_OFS, 32'h0);
    rd("thr", DPM_THR_BASE, DPM_THR_RESET);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, rd_e});
    apb(1'b1, 12'h042, 32'h0);
    chk("slverr", 32'h1, {31'h0, rd_e});
    pstrb <= 4'h2;
    wr(DPM_THR_BASE + 12'h004, 32'h0000_1200);
    pstrb <= 4'hf;
    rd("thr_strb", DPM_THR_BASE + 12'h004, 32'hffff_12ff);
    for (int i = 0; i < 10; i++) begin
      wait_at(100);
      wr(DPM_CTRL_OFS, {31'h0, rows[i].esf});
      for (int j = 0; j < 10; j++) wr(DPM_PM_BASE + 12'(4 * j), 32'h0);
      fr.send(rows[i].l, rows[i].p, '0, rows[i].n);
      wait_at(50);
      for (int j = 0; j < 10; j++)
        rd($sformatf("pm%0d", j), DPM_PM_BASE + 12'(4 * j), 32'(rows[i].e[j]));
    end
    // one clean second, then ten severe ones
    wait_at(100);
    wr(DPM_PM_BASE + 12'h024, 32'h0);
    for (int i = 0; i < 10; i++) begin
      ses_second();
      if (i == 8) chk("unav9", 32'h0, {31'h0, unav});
    end
    chk("unav", 32'h1, {31'h0, unav});
    rd("uas", DPM_PM_BASE + 12'h024, 32'd10);
    rd("status", DPM_STATUS_OFS, 32'h1);
    // three clean seconds broken by a severe one count as unavailable
    repeat (3) wait_at(50);
    ses_second();
    repeat (9) wait_at(50);
    chk("unav", 32'h1, {31'h0, unav});
    wait_at(50);
    chk("unav", 32'h0, {31'h0, unav});
    rd("uas", DPM_PM_BASE + 12'h024, 32'd14);
    wr(DPM_CTRL_OFS, 32'h0000_0502);
    for (int j = 0; j < 4; j++) wr(DPM_PJ_BASE + 12'(4 * j), 32'h0);
    fr.send('0, '0, {6'd5, 4'hf}, 2);
    fr.send('0, '0, {6'd6, 4'hf}, 3);
    fr.send('0, '0, {6'd5, 4'h8}, 1);
    for (int j = 0; j < 4; j++)
      rd($sformatf("pj%0d", j), DPM_PJ_BASE + 12'(4 * j), (j == 0) ? 32'd3 : 32'd2);
    wr(DPM_CTRL_OFS, 32'h0000_0500);
    rd("pj_off", DPM_PJ_BASE, 32'h0);
    wr(DPM_PM_BASE, 32'h0);
    wr(DPM_THR_BASE, 32'h3);
    wr(DPM_FLAGS_OFS, 32'h3ff);
    fr.send(3'b100, '0, '0, 2);
    @(negedge clk);
    chk("flag", 32'h0, {22'h0, flags});
    fr.send(3'b100, '0, '0, 1);
    rd("flags", DPM_FLAGS_OFS, 32'h1);
    wr(DPM_FLAGS_OFS, 32'h1);
    // the clear lands at the completing edge, so look once it has settled
    @(negedge clk);
    chk("flag", 32'h0, {22'h0, flags});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd("pm0", DPM_PM_BASE, 32'h0);
    rd("thr", DPM_THR_BASE, DPM_THR_RESET);
    close_out();
  end
endmodule // dpm_monitor_tb
